// ===== esb_pkg.sv
// Purpose: Shared constants for the emergency stop brake sequencer
// Assumes: AXI4-Lite register access, 32-bit data, 50 MHz clock
// Notes:   Delays are held in registers as module clock ticks
package esb_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ESB_CTRL_OFS      = 8'h00;
    localparam logic [7:0] ESB_STATE_OFS     = 8'h04;
    localparam logic [7:0] ESB_STOP_DLY_OFS  = 8'h08;
    localparam logic [7:0] ESB_EXTRA_DLY_OFS = 8'h0c;
    localparam logic [7:0] ESB_BRK_DLY_OFS   = 8'h10;
    localparam logic [7:0] ESB_BRK_ZERO_OFS  = 8'h14;
    localparam logic [7:0] ESB_BRK_SPD_OFS   = 8'h18;
    localparam logic [7:0] ESB_ZERO_SPD_OFS  = 8'h1c;
    localparam logic [7:0] ESB_RAMP_MIN_OFS  = 8'h20;
    localparam logic [7:0] ESB_RAMP_MAX_OFS  = 8'h24;
    localparam logic [7:0] ESB_IRQ_STAT_OFS  = 8'h28;
    localparam logic [7:0] ESB_IRQ_MASK_OFS  = 8'h2c;
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int ESB_CTRL_RAMP_MODE_BIT = 0;
    localparam int ESB_CTRL_ENC_BIT       = 1;
    localparam int ESB_CTRL_ACK_BIT       = 2;
    // ------------------------------------------------------------
    // Event bits
    // ------------------------------------------------------------
    localparam int ESB_EV_STOP_BIT  = 0;
    localparam int ESB_EV_BRAKE_BIT = 1;
    localparam int ESB_EV_TO_BIT    = 2;
    localparam int ESB_EV_DONE_BIT  = 3;
    localparam int ESB_EV_RAMP_BIT  = 4;
    localparam int ESB_EV_W         = 5;
    // ------------------------------------------------------------
    // Reset values, AXI response codes and state encoding
    // ------------------------------------------------------------
    localparam logic [31:0] ESB_DLY_RST  = 32'h0000_0000;
    localparam logic [15:0] ESB_SPD_RST  = 16'h0000;
    localparam logic [1:0]  ESB_AXI_OKAY   = 2'b00;
    localparam logic [1:0]  ESB_AXI_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        ESB_IDLE  = 3'b000,
        ESB_DECEL = 3'b001,
        ESB_EXTRA = 3'b011,
        ESB_BRAKE = 3'b010,
        ESB_DONE  = 3'b110
    } esb_state_e;
endpackage

// ===== esb_sequencer.sv
// Purpose: Emergency stop sequencer; brake engages before torque off except on stop timer expiry or ramp fault
// Assumes: stop_req and ack_req are asynchronous pins; speed is same-clock
// Notes:   Time or ramp supervision, encoder or brake-timer completion
// Function
// - Time mode: stop request raises stop-active and starts stop-to-torque-off timer.
// - Time mode: speed below brake limit engages brake, starts brake timer.
// - Optional extra delay precedes brake; torque off shifts equally later.
// - Stop-to-torque-off timer expiry forces torque off whatever the speed.
// - Brake-to-torque-off expiry activates torque off and its indication.
// - Encoder: zero-speed threshold completes stop; ack only after request removed.
// - Valid ack releases stop, brake, torque off and all indications.
// - Ramp mode: check deceleration against min and max limits once decelerating.
// - Ramp timed: brake limit brakes; brake engagement stops checks, starts both brake timers.
// - Ramp limit crossed while checking immediately activates torque off.
// - Brake time-to-zero expiry completes stop; ack only after request removed.
// - Ramp mode with encoder: zero speed stops checks and completes stop.
module esb_sequencer
    import esb_pkg::*;
#(
    parameter int SPD_W = 16
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Safety pins and drive status
    input  wire logic              stop_req,
    input  wire logic              ack_req,
    input  wire logic [SPD_W-1:0]  motor_speed,
    input  wire logic              drive_decel,
    // Actuators and indications
    output logic                   brake_control,
    output logic                   torque_off,
    output logic                   drive_stop_cmd,
    output logic                   stop_active_indication,
    output logic                   stop_completed_indication,
    output logic                   torque_off_indication,
    output logic                   irq,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] stop_sync_r;
    logic [1:0] ack_sync_r;
    logic       ack_prev_r;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stop_sync_r <= 2'b00;
            ack_sync_r  <= 2'b00;
            ack_prev_r  <= 1'b0;
        end
        else
        begin
            stop_sync_r <= {stop_sync_r[0], stop_req};
            ack_sync_r  <= {ack_sync_r[0], ack_req};
            ack_prev_r  <= ack_sync_r[1];
        end
    end
    wire stop_s   = stop_sync_r[1];
    wire ack_rise = ack_sync_r[1] & ~ack_prev_r;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic             ramp_mode_r;
    logic             enc_mode_r;
    logic             sw_ack_r;
    logic [31:0]      stop_dly_r;
    logic [31:0]      extra_dly_r;
    logic [31:0]      brk_dly_r;
    logic [31:0]      brk_zero_r;
    logic [SPD_W-1:0] brk_spd_r;
    logic [SPD_W-1:0] zero_spd_r;
    logic [SPD_W-1:0] ramp_min_r;
    logic [SPD_W-1:0] ramp_max_r;
    logic [ESB_EV_W-1:0] irq_stat_r;
    logic [ESB_EV_W-1:0] irq_mask_r;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    esb_state_e  state_r;
    logic [31:0] stop_cnt_r;
    logic [31:0] extra_cnt_r;
    logic [31:0] brk_cnt_r;
    logic [31:0] zero_cnt_r;
    logic        stop_tmr_on_r;
    logic        ramp_chk_r;

    wire below_brake = motor_speed < brk_spd_r;
    wire at_zero     = motor_speed <= zero_spd_r;
    wire ramp_fault  = ramp_chk_r & ((motor_speed < ramp_min_r) | (motor_speed > ramp_max_r));
    wire stop_expire = stop_tmr_on_r & (stop_cnt_r >= stop_dly_r);
    wire extra_done  = extra_cnt_r >= extra_dly_r;
    wire brk_expire  = (state_r == ESB_BRAKE) & (brk_cnt_r >= brk_dly_r);
    wire zero_expire = (state_r == ESB_BRAKE) & (zero_cnt_r >= brk_zero_r);
    wire enc_done    = enc_mode_r & at_zero & (state_r != ESB_IDLE);
    wire tim_done    = ~enc_mode_r & zero_expire;
    wire complete    = (enc_done | tim_done) & (state_r != ESB_DONE);
    wire ack_ok      = (state_r == ESB_DONE) & ~stop_s & (ack_rise | sw_ack_r);
    wire to_trigger  = stop_expire | brk_expire | ramp_fault;
    wire start_stop  = (state_r == ESB_IDLE) & stop_s;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r                   <= ESB_IDLE;
            stop_cnt_r                <= ESB_DLY_RST;
            extra_cnt_r               <= ESB_DLY_RST;
            brk_cnt_r                 <= ESB_DLY_RST;
            zero_cnt_r                <= ESB_DLY_RST;
            stop_tmr_on_r             <= 1'b0;
            ramp_chk_r                <= 1'b0;
            brake_control             <= 1'b0;
            torque_off                <= 1'b0;
            drive_stop_cmd            <= 1'b0;
            stop_active_indication    <= 1'b0;
            stop_completed_indication <= 1'b0;
            torque_off_indication     <= 1'b0;
        end
        else
        begin
            // Timers tick from their own start events
            if (stop_tmr_on_r && !stop_expire)
                stop_cnt_r <= stop_cnt_r + 32'h1;
            if (state_r == ESB_EXTRA && !extra_done)
                extra_cnt_r <= extra_cnt_r + 32'h1;
            if (state_r == ESB_BRAKE && !brk_expire)
                brk_cnt_r <= brk_cnt_r + 32'h1;
            if (state_r == ESB_BRAKE && !zero_expire)
                zero_cnt_r <= zero_cnt_r + 32'h1;
            if (to_trigger && state_r != ESB_IDLE)
            begin
                torque_off            <= 1'b1;
                torque_off_indication <= 1'b1;
            end
            if (complete)
            begin
                state_r                   <= ESB_DONE;
                ramp_chk_r                <= 1'b0;
                stop_completed_indication <= 1'b1;
            end
            case (state_r)
                ESB_IDLE:
                begin
                    if (start_stop)
                    begin
                        state_r                <= ESB_DECEL;
                        stop_active_indication <= 1'b1;
                        drive_stop_cmd         <= 1'b1;
                        stop_tmr_on_r          <= ~ramp_mode_r;
                        stop_cnt_r             <= ESB_DLY_RST;
                        extra_cnt_r            <= ESB_DLY_RST;
                        brk_cnt_r              <= ESB_DLY_RST;
                        zero_cnt_r             <= ESB_DLY_RST;
                    end
                end
                ESB_DECEL:
                begin
                    if (ramp_mode_r && drive_decel && !complete)
                        ramp_chk_r <= 1'b1;
                    if (below_brake && !complete)
                        state_r <= ESB_EXTRA;
                end
                ESB_EXTRA:
                begin
                    if (extra_done && !complete)
                    begin
                        state_r       <= ESB_BRAKE;
                        brake_control <= 1'b1;
                        ramp_chk_r    <= 1'b0;
                    end
                end
                ESB_BRAKE:
                begin
                end
                ESB_DONE:
                begin
                    if (ack_ok)
                    begin
                        state_r                   <= ESB_IDLE;
                        stop_tmr_on_r             <= 1'b0;
                        ramp_chk_r                <= 1'b0;
                        brake_control             <= 1'b0;
                        torque_off                <= 1'b0;
                        drive_stop_cmd            <= 1'b0;
                        stop_active_indication    <= 1'b0;
                        stop_completed_indication <= 1'b0;
                        torque_off_indication     <= 1'b0;
                    end
                end
                default:
                    state_r <= ESB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    wire [ESB_EV_W-1:0] ev_vec = {ramp_fault, complete, to_trigger & ~torque_off,
                                  (state_r == ESB_EXTRA) & extra_done, start_stop};

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [7:0] aw_addr_r;
    logic       aw_held_r;
    logic       w_held_r;
    logic [31:0] w_data_r;
    wire  do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire  wr_stat  = do_write & (aw_addr_r == ESB_IRQ_STAT_OFS);
    wire  [ESB_EV_W-1:0] stat_clr = wr_stat ? w_data_r[ESB_EV_W-1:0] : '0;
    wire  wr_hit   = (aw_addr_r <= ESB_IRQ_MASK_OFS) & (aw_addr_r[1:0] == 2'b00)
                     & (aw_addr_r != ESB_STATE_OFS);
    wire  rd_hit   = (s_axi_araddr <= ESB_IRQ_MASK_OFS) & (s_axi_araddr[1:0] == 2'b00);
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        case (s_axi_araddr)
            ESB_CTRL_OFS:      rd_mux = {30'h0, enc_mode_r, ramp_mode_r};
            ESB_STATE_OFS:     rd_mux = {24'h0, ramp_chk_r, state_r, brake_control,
                                         torque_off_indication, stop_completed_indication,
                                         stop_active_indication};
            ESB_STOP_DLY_OFS:  rd_mux = stop_dly_r;
            ESB_EXTRA_DLY_OFS: rd_mux = extra_dly_r;
            ESB_BRK_DLY_OFS:   rd_mux = brk_dly_r;
            ESB_BRK_ZERO_OFS:  rd_mux = brk_zero_r;
            ESB_BRK_SPD_OFS:   rd_mux = {16'h0, brk_spd_r};
            ESB_ZERO_SPD_OFS:  rd_mux = {16'h0, zero_spd_r};
            ESB_RAMP_MIN_OFS:  rd_mux = {16'h0, ramp_min_r};
            ESB_RAMP_MAX_OFS:  rd_mux = {16'h0, ramp_max_r};
            ESB_IRQ_STAT_OFS:  rd_mux = {27'h0, irq_stat_r};
            ESB_IRQ_MASK_OFS:  rd_mux = {27'h0, irq_mask_r};
            default:           rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held_r <= 1'b0; w_held_r <= 1'b0;
            aw_addr_r <= 8'h00; w_data_r <= 32'h0;
            s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= ESB_AXI_OKAY;
            s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0; s_axi_rresp <= ESB_AXI_OKAY;
            ramp_mode_r <= 1'b0; enc_mode_r <= 1'b0; sw_ack_r <= 1'b0;
            stop_dly_r <= ESB_DLY_RST; extra_dly_r <= ESB_DLY_RST;
            brk_dly_r <= ESB_DLY_RST; brk_zero_r <= ESB_DLY_RST;
            brk_spd_r <= ESB_SPD_RST; zero_spd_r <= ESB_SPD_RST;
            ramp_min_r <= ESB_SPD_RST; ramp_max_r <= ESB_SPD_RST;
            irq_stat_r <= '0; irq_mask_r <= '0; irq <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
            end
            sw_ack_r <= 1'b0;
            if (do_write)
            begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? ESB_AXI_OKAY : ESB_AXI_SLVERR;
                case (aw_addr_r)
                    ESB_CTRL_OFS:
                    begin
                        ramp_mode_r <= w_data_r[ESB_CTRL_RAMP_MODE_BIT];
                        enc_mode_r  <= w_data_r[ESB_CTRL_ENC_BIT];
                        sw_ack_r    <= w_data_r[ESB_CTRL_ACK_BIT];
                    end
                    ESB_STOP_DLY_OFS:  stop_dly_r  <= w_data_r;
                    ESB_EXTRA_DLY_OFS: extra_dly_r <= w_data_r;
                    ESB_BRK_DLY_OFS:   brk_dly_r   <= w_data_r;
                    ESB_BRK_ZERO_OFS:  brk_zero_r  <= w_data_r;
                    ESB_BRK_SPD_OFS:   brk_spd_r   <= w_data_r[SPD_W-1:0];
                    ESB_ZERO_SPD_OFS:  zero_spd_r  <= w_data_r[SPD_W-1:0];
                    ESB_RAMP_MIN_OFS:  ramp_min_r  <= w_data_r[SPD_W-1:0];
                    ESB_RAMP_MAX_OFS:  ramp_max_r  <= w_data_r[SPD_W-1:0];
                    ESB_IRQ_MASK_OFS:  irq_mask_r  <= w_data_r[ESB_EV_W-1:0];
                    default:           irq_mask_r  <= irq_mask_r;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Set wins over write-one-to-clear
            irq_stat_r <= (irq_stat_r & ~stat_clr) | ev_vec;
            irq        <= |(irq_stat_r & irq_mask_r);
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? ESB_AXI_OKAY : ESB_AXI_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== esb_sequencer_sva.sv
// Purpose: Port-level checks for the emergency stop brake sequencer
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached to every sequencer instance by bind
module esb_sequencer_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Stop pin and outputs
    input wire logic        stop_req,
    input wire logic        brake_control,
    input wire logic        torque_off,
    input wire logic        drive_stop_cmd,
    input wire logic        stop_active_indication,
    input wire logic        stop_completed_indication,
    input wire logic        torque_off_indication,
    // AXI4-Lite
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_stop_held; $rose(stop_req) ##1 stop_req [*3]; endsequence
    sequence s_release; $fell(stop_active_indication); endsequence
    property p_start; s_stop_held |=> stop_active_indication && drive_stop_cmd; endproperty
    a_start: assert property (p_start) else $error("stop not raised");
    property p_to_act; torque_off |-> stop_active_indication; endproperty
    a_to_act: assert property (p_to_act) else $error("torque off while idle");
    property p_brk_act; brake_control |-> stop_active_indication; endproperty
    a_brk_act: assert property (p_brk_act) else $error("brake while idle");
    property p_to_ind; torque_off |-> ##[0:1] torque_off_indication; endproperty
    a_to_ind: assert property (p_to_ind) else $error("no torque off indication");
    property p_to_hold; $fell(torque_off) |-> !stop_active_indication; endproperty
    a_to_hold: assert property (p_to_hold) else $error("torque off dropped early");
    property p_release; s_release |-> !torque_off && !brake_control && !drive_stop_cmd
        && !stop_completed_indication && !torque_off_indication; endproperty
    a_release: assert property (p_release) else $error("partial release");
    property p_ack_gate; s_release |-> $past(stop_completed_indication) && !$past(stop_req, 3);
    endproperty
    a_ack_gate: assert property (p_ack_gate) else $error("early acknowledge");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rlat; s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule

bind esb_sequencer esb_sequencer_sva u_sva (.clk(clk), .sys_rst(sys_rst), .stop_req(stop_req),
    .brake_control(brake_control), .torque_off(torque_off), .drive_stop_cmd(drive_stop_cmd),
    .stop_active_indication(stop_active_indication),
    .stop_completed_indication(stop_completed_indication),
    .torque_off_indication(torque_off_indication), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ===== esb_drive_model.sv
// Purpose: Drive that ramps the motor down on a stop command
// Assumes: Step per cycle is set by the bench, zero means no ramp
// Notes:   Motor keeps coasting after torque off
module esb_drive_model #(
    parameter int          RESP = 4,
    parameter logic [15:0] SPD0 = 16'h1000
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Sequencer side
    input  wire logic        drive_stop_cmd,
    input  wire logic [15:0] decel_step,
    output logic [15:0]      motor_speed,
    output logic             drive_decel
);
    timeunit 1ns;
    timeprecision 1ns;
    int resp_cnt;
    always @(posedge clk)
    begin
        if (sys_rst || !drive_stop_cmd)
        begin
            resp_cnt <= 0;
            motor_speed <= SPD0;
            drive_decel <= 1'b0;
        end
        else if (resp_cnt < RESP)
            resp_cnt <= resp_cnt + 1;
        else
        begin
            motor_speed <= (motor_speed > decel_step) ? motor_speed - decel_step : 16'h0000;
            drive_decel <= 1'b1;
        end
    end
endmodule

// ===== emergency_stop_brake_sequencer_bench.sv
// Purpose: Self-checking bench for the emergency stop brake sequencer
// Assumes: Drive model on the speed side, AXI4-Lite master tasks
// Notes:   Delay checks allow one cycle of output register lag, the brake delay check up to three
module emergency_stop_brake_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import esb_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, stop_req = 1'b0, ack_req = 1'b0;
    logic [15:0] motor_speed, decel_step = 16'h0040;
    logic drive_decel, brake_control, torque_off, drive_stop_cmd, irq;
    logic stop_active_indication, stop_completed_indication, torque_off_indication;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int mismatches = 0, tests_run = 0, cycles = 0, t0, t1;
    esb_sequencer dut (.clk, .sys_rst, .stop_req, .ack_req, .motor_speed, .drive_decel,
        .brake_control, .torque_off, .drive_stop_cmd, .stop_active_indication,
        .stop_completed_indication, .torque_off_indication, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    esb_drive_model drv (.clk, .sys_rst, .drive_stop_cmd, .decel_step, .motor_speed, .drive_decel);
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, er);
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cfg(input logic [31:0] v [8]);
        for (int i = 0; i < 8; i++) axi_wr(ESB_STOP_DLY_OFS + 8'(4 * i), v[i], ESB_AXI_OKAY);
    endtask
    task automatic pulse_ack();
        ack_req <= 1'b1;
        repeat (4) @(posedge clk);
        ack_req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic release_stop();
        stop_req <= 1'b0;
        repeat (4) @(posedge clk);
        pulse_ack();
        check("released", {brake_control, torque_off, drive_stop_cmd, stop_active_indication,
            stop_completed_indication, torque_off_indication}, 32'h0);
    endtask
    task automatic run_timed(input logic [31:0] ctrl);
        axi_wr(ESB_CTRL_OFS, ctrl, ESB_AXI_OKAY);
        cfg('{1000, 3, 10, 40, 32'h0800, 0, 0, 32'hffff});
        decel_step <= 16'h0040;
        stop_req <= 1'b1;
        while (!(drive_stop_cmd && motor_speed < 16'h0800)) @(posedge clk);
        t0 = cycles;
        while (!brake_control) @(posedge clk);
        t1 = cycles;
        check("brake delay", (t1 - t0 >= 3) && (t1 - t0 <= 6), 1);
        while (!torque_off) @(posedge clk);
        check("torque off", (cycles - t1 >= 10) && (cycles - t1 <= 11), 1);
        while (!stop_completed_indication) @(posedge clk);
        check("zero timer", (cycles - t1 >= 40) && (cycles - t1 <= 41), 1);
        pulse_ack();
        check("ack refused", stop_active_indication, 1'b1);
        axi_rd(ESB_IRQ_STAT_OFS);
        check("irq status", rd, 32'hf);
        axi_wr(ESB_IRQ_MASK_OFS, 32'h1f, ESB_AXI_OKAY);
        check("irq on", irq, 1'b1);
        axi_wr(ESB_IRQ_MASK_OFS, 32'h0, ESB_AXI_OKAY);
        check("irq masked", irq, 1'b0);
        axi_wr(ESB_IRQ_STAT_OFS, 32'h1f, ESB_AXI_OKAY);
        axi_rd(ESB_IRQ_STAT_OFS);
        check("irq cleared", rd, 32'h0);
        release_stop();
        $display("timed stop test done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(ESB_BRK_DLY_OFS);
        check("delay reset", rd, ESB_DLY_RST);
        axi_rd(8'h40);
        check("unmapped", {rd, rs}, {32'h0, ESB_AXI_SLVERR});
        axi_wr(ESB_STATE_OFS, 32'h1, ESB_AXI_SLVERR);
        $display("bus test done");
        run_timed(32'h0);
        run_timed(32'h1);
        cfg('{50, 0, 5, 20, 32'h0800, 0, 0, 32'hffff});
        axi_wr(ESB_CTRL_OFS, 32'h2, ESB_AXI_OKAY);
        decel_step <= 16'h0000;
        stop_req <= 1'b1;
        while (!stop_active_indication) @(posedge clk);
        t0 = cycles;
        while (!torque_off) @(posedge clk);
        check("forced off", (cycles - t0 >= 50) && (cycles - t0 <= 51), 1);
        check("no brake", brake_control, 1'b0);
        decel_step <= 16'h0100;
        while (!stop_completed_indication) @(posedge clk);
        stop_req <= 1'b0;
        repeat (4) @(posedge clk);
        axi_wr(ESB_CTRL_OFS, 32'h4, ESB_AXI_OKAY);
        check("soft ack", stop_active_indication, 1'b0);
        $display("forced torque off test done");
        cfg('{1000, 0, 5, 1000, 32'h0400, 32'h0010, 32'h0c00, 32'hffff});
        axi_wr(ESB_CTRL_OFS, 32'h3, ESB_AXI_OKAY);
        stop_req <= 1'b1;
        while (!torque_off) @(posedge clk);
        check("ramp fault", {brake_control, motor_speed < 16'h0c00}, 2'b01);
        while (!stop_completed_indication) @(posedge clk);
        check("zero speed", motor_speed <= 16'h0010, 1'b1);
        axi_rd(ESB_IRQ_STAT_OFS);
        check("ramp event", rd[ESB_EV_RAMP_BIT], 1'b1);
        axi_wr(ESB_IRQ_STAT_OFS, 32'h1f, ESB_AXI_OKAY);
        release_stop();
        $display("ramp fault test done");
        stop_req <= 1'b1;
        while (!stop_active_indication) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        check("reset clears", {stop_active_indication, drive_stop_cmd, irq}, 3'h0);
        $display("reset test done");
        final_report();
    end
endmodule
